// File: rtl/period_timer_defines.svh
// named offsets, field positions, reset values and timing counts for the period match timer
`ifndef PERIOD_TIMER_DEFINES_SVH
`define PERIOD_TIMER_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------
`define TMR_OFS_COUNT     5'h00
`define TMR_OFS_PERIOD    5'h04
`define TMR_OFS_CONTROL   5'h08
`define TMR_OFS_FLAGS     5'h0C
`define TMR_OFS_CLEAR     5'h10
`define TMR_OFS_ENABLES   5'h14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TMR_COUNT_RST     8'h00
`define TMR_PERIOD_RST    8'hFF
`define TMR_CONTROL_RST   7'h00

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define TMR_CTL_PRE_LO    0
`define TMR_CTL_PRE_HI    1
`define TMR_CTL_RUN       2
`define TMR_CTL_POST_LO   3
`define TMR_CTL_POST_HI   6
`define TMR_CTL_MSB       6

// match flag / enable bit inside the flag, clear and enable words
`define TMR_IRQ_BIT       1

// ----------------------------------------------------------------
// prescale select codes and terminal counts
// ----------------------------------------------------------------
`define TMR_PRE_DIV1      2'h0
`define TMR_PRE_DIV4      2'h1
`define TMR_PRE_TERM1     4'h0
`define TMR_PRE_TERM4     4'h3
`define TMR_PRE_TERM16    4'hF

// instruction clock: oscillator divided by four
`define TMR_FOSC_TERM     2'h3

`endif

// File: rtl/period_timer_pkg.sv
// types shared by the period match timer files
package period_timer_pkg;

    // axi4-lite response codes
    typedef enum logic [1:0]
    {
        RESP_OKAY   = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_t;

endpackage : period_timer_pkg

// File: rtl/prescale_divider.sv
// prescaler: divides the instruction tick by 1, 4 or 16
`timescale 1ns/1ps
`include "period_timer_defines.svh"

module prescale_divider
#(
    parameter int CW = 4                       // counter width, fits divide by 16
)
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          tick_en,        // instruction clock enable
    input  wire logic          run,            // timer on
    input  wire logic          clear,          // clear counter (register write)
    input  wire logic [1:0]    select,         // prescale select
    output      logic          pulse           // one-cycle prescaled tick
);

    logic [CW-1:0] cnt_reg;                    // prescale count
    logic [CW-1:0] term;                       // terminal count for the select

    // ----------------------------------------------------------------
    // terminal count; codes 10 and 11 both mean sixteen
    // ----------------------------------------------------------------
    always_comb
    begin
        case (select)
            `TMR_PRE_DIV1: term = `TMR_PRE_TERM1; // R2
            `TMR_PRE_DIV4: term = `TMR_PRE_TERM4; // R2
            default:       term = `TMR_PRE_TERM16; // R2
        endcase
    end

    // a clearing write swallows a tick in the same cycle
    assign pulse = run && tick_en && !clear && (cnt_reg == term); // R10

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b || clear)
            cnt_reg <= '0; // R9
        else if (run && tick_en) // R13
        begin
            if (cnt_reg == term)
                cnt_reg <= '0;
            else
                cnt_reg <= cnt_reg + 1'b1;
        end
    end

    property p_pre_clear;
        @(posedge clk) disable iff (!rst_b) clear |=> (cnt_reg == '0);
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared"); // R9

    property p_pre_div4;
        @(posedge clk) disable iff (!rst_b)
            (pulse && select == `TMR_PRE_DIV4) |=>
                (!pulse || select != `TMR_PRE_DIV4) [*8] ##1 (!pulse || select != `TMR_PRE_DIV4) [*7];
    endproperty
    a_pre_div4: assert property (p_pre_div4) else $error("divide by four too fast"); // R2

endmodule : prescale_divider

// File: rtl/postscale_counter.sv
// postscaler: one output pulse per 1 to 16 period matches
`timescale 1ns/1ps
`include "period_timer_defines.svh"

module postscale_counter
#(
    parameter int CW = 4                       // select and counter width
)
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          match,          // count reached period
    input  wire logic          clear,          // clear counter (register write)
    input  wire logic [CW-1:0] select,         // divide by select + 1
    output      logic          pulse           // one-cycle postscaled event
);

    logic [CW-1:0] cnt_reg;                    // matches seen so far

    assign pulse = match && (cnt_reg == select); // R6

    // ----------------------------------------------------------------
    // counter; a select lowered below the count waits for a wrap
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b || clear)
            cnt_reg <= '0; // R9
        else if (match) // R5
        begin
            if (cnt_reg == select)
                cnt_reg <= '0;
            else
                cnt_reg <= cnt_reg + 1'b1;
        end
    end

    property p_post_one;
        @(posedge clk) disable iff (!rst_b) (match && select == '0) |-> pulse;
    endproperty
    a_post_one: assert property (p_post_one) else $error("1:1 postscale missed"); // R6

endmodule : postscale_counter

// File: rtl/period_match_timer8.sv
// period match timer with prescaler, postscaler, interrupt and axi4-lite registers
// What this block does
// [R1] timer clock is oscillator divided by four
// [R2] prescaler divides by 1, 4 or 16
// [R3] each prescaled tick advances the count
// [R4] count equal to period wraps to zero
// [R5] each match advances postscaler, output sets flag
// [R6] postscale field selects 1 to 16 matches
// [R7] count and period readable, reset 00h/FFh
// [R8] on bit runs and stops the timer
// [R9] count or control writes clear scalers
// [R10] control writes keep the count value
// [R11] flag stays set until software clears
// [R12] flag sets regardless of any enable
// [R13] stopped timer holds counters, makes no events
`timescale 1ns/1ps
`include "period_timer_defines.svh"

module period_match_timer8
#(
    parameter int ADDR_W = 5                   // byte address width
)
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] axi_awaddr,
    input  wire logic              axi_awvalid,
    output      logic              axi_awready,
    input  wire logic [31:0]       axi_wdata,
    input  wire logic [3:0]        axi_wstrb,
    input  wire logic              axi_wvalid,
    output      logic              axi_wready,
    output      logic [1:0]        axi_bresp,
    output      logic              axi_bvalid,
    input  wire logic              axi_bready,
    input  wire logic [ADDR_W-1:0] axi_araddr,
    input  wire logic              axi_arvalid,
    output      logic              axi_arready,
    output      logic [31:0]       axi_rdata,
    output      logic [1:0]        axi_rresp,
    output      logic              axi_rvalid,
    input  wire logic              axi_rready,
    output      logic              irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [1:0]  fosc_cnt_reg;                 // oscillator to instruction divider
    logic        ins_tick;                     // instruction clock enable
    logic [7:0]  count_reg;                    // timer count
    logic [7:0]  period_reg;                   // period value
    logic [`TMR_CTL_MSB:0] control_reg;        // control bits 6..0
    logic        flag_reg;                     // match interrupt flag
    logic        enable_reg;                   // match interrupt enable
    logic        irq_reg;                      // registered interrupt level
    logic        pre_pulse;                    // prescaled tick
    logic        match;                        // count equals period on a tick
    logic        post_pulse;                   // postscaled event
    logic        run;                          // timer on

    // bus side
    logic        wr_take_reg;                  // write address and data taken now
    logic        bvalid_reg;
    period_timer_pkg::axi_resp_t bresp_reg;
    logic        ar_take_reg;                  // read address taken now
    logic        rvalid_reg;
    period_timer_pkg::axi_resp_t rresp_reg;
    logic [31:0] rdata_reg;

    // decoded write strobes, valid only in the taking cycle
    logic        wr_lane0;
    logic        wr_count;
    logic        wr_period;
    logic        wr_control;
    logic        wr_clear;
    logic        wr_enable;
    logic        wr_mapped;
    logic        scaler_clear;

    assign run = control_reg[`TMR_CTL_RUN]; // R8

    // ----------------------------------------------------------------
    // instruction clock: a free-running quarter-rate enable
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            fosc_cnt_reg <= 2'h0;
        else
            fosc_cnt_reg <= fosc_cnt_reg + 2'h1; // R1
    end

    assign ins_tick = (fosc_cnt_reg == `TMR_FOSC_TERM); // R1

    // ----------------------------------------------------------------
    // write address decode
    // ----------------------------------------------------------------
    // the master holds awaddr and wdata until taken, so decoding them
    // in the take cycle is safe
    assign wr_lane0   = wr_take_reg && axi_wstrb[0];
    assign wr_count   = wr_lane0 && (axi_awaddr == `TMR_OFS_COUNT);
    assign wr_period  = wr_lane0 && (axi_awaddr == `TMR_OFS_PERIOD);
    assign wr_control = wr_lane0 && (axi_awaddr == `TMR_OFS_CONTROL);
    assign wr_clear   = wr_lane0 && (axi_awaddr == `TMR_OFS_CLEAR);
    assign wr_enable  = wr_lane0 && (axi_awaddr == `TMR_OFS_ENABLES);

    always_comb
    begin
        case (axi_awaddr)
            `TMR_OFS_COUNT, `TMR_OFS_PERIOD, `TMR_OFS_CONTROL,
            `TMR_OFS_FLAGS, `TMR_OFS_CLEAR, `TMR_OFS_ENABLES:
                wr_mapped = 1'b1;
            default:
                wr_mapped = 1'b0;
        endcase
    end

    // writes to count or control restart both scalers
    assign scaler_clear = wr_count || wr_control; // R9

    // ----------------------------------------------------------------
    // scalers
    // ----------------------------------------------------------------
    prescale_divider
    #(
        .CW      (4)
    )
    u_pre
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .tick_en (ins_tick),
        .run     (run),
        .clear   (scaler_clear),
        .select  (control_reg[`TMR_CTL_PRE_HI:`TMR_CTL_PRE_LO]),
        .pulse   (pre_pulse)
    );

    // a count write overrides the tick, so no match in that cycle
    assign match = pre_pulse && !wr_count && (count_reg == period_reg); // R4

    postscale_counter
    #(
        .CW      (4)
    )
    u_post
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .match   (match),
        .clear   (scaler_clear),
        .select  (control_reg[`TMR_CTL_POST_HI:`TMR_CTL_POST_LO]),
        .pulse   (post_pulse)
    );

    // ----------------------------------------------------------------
    // count register; software write wins over a tick
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            count_reg <= `TMR_COUNT_RST; // R7
        else if (wr_count)
            count_reg <= axi_wdata[7:0]; // R7
        else if (match)
            count_reg <= `TMR_COUNT_RST; // R4
        else if (pre_pulse)
            count_reg <= count_reg + 8'h01; // R3
        // control writes fall through and leave the count alone
    end

    // ----------------------------------------------------------------
    // period and control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            period_reg <= `TMR_PERIOD_RST; // R7
        else if (wr_period)
            period_reg <= axi_wdata[7:0]; // R7
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            control_reg <= `TMR_CONTROL_RST;
        else if (wr_control)
            control_reg <= axi_wdata[`TMR_CTL_MSB:0]; // R8
    end

    // ----------------------------------------------------------------
    // interrupt flag: sticky, set beats a same-cycle clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            flag_reg <= 1'b0;
        else if (post_pulse)
            flag_reg <= 1'b1; // R5 R12
        else if (wr_clear && axi_wdata[`TMR_IRQ_BIT])
            flag_reg <= 1'b0; // R11
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            enable_reg <= 1'b0;
        else if (wr_enable)
            enable_reg <= axi_wdata[`TMR_IRQ_BIT];
    end

    // one cycle behind the flag so the output leaves a flop
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            irq_reg <= 1'b0;
        else
            irq_reg <= flag_reg && enable_reg;
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel: take both together, then respond
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wr_take_reg <= 1'b0;
        else
            wr_take_reg <= axi_awvalid && axi_wvalid && !wr_take_reg && !bvalid_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= period_timer_pkg::RESP_OKAY;
        end
        else if (wr_take_reg)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? period_timer_pkg::RESP_OKAY : period_timer_pkg::RESP_SLVERR;
        end
        else if (axi_bready)
            bvalid_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            ar_take_reg <= 1'b0;
        else
            ar_take_reg <= axi_arvalid && !ar_take_reg && !rvalid_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= period_timer_pkg::RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end
        else if (ar_take_reg)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= period_timer_pkg::RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
            case (axi_araddr)
                `TMR_OFS_COUNT:   rdata_reg[7:0] <= count_reg; // R7
                `TMR_OFS_PERIOD:  rdata_reg[7:0] <= period_reg; // R7
                `TMR_OFS_CONTROL: rdata_reg[`TMR_CTL_MSB:0] <= control_reg;
                `TMR_OFS_FLAGS:   rdata_reg[`TMR_IRQ_BIT] <= flag_reg;
                `TMR_OFS_ENABLES: rdata_reg[`TMR_IRQ_BIT] <= enable_reg;
                `TMR_OFS_CLEAR:   rdata_reg[`TMR_IRQ_BIT] <= 1'b0;
                default:          rresp_reg <= period_timer_pkg::RESP_SLVERR;
            endcase
        end
        else if (axi_rready)
            rvalid_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign axi_awready = wr_take_reg;
    assign axi_wready  = wr_take_reg;
    assign axi_bvalid  = bvalid_reg;
    assign axi_bresp   = bresp_reg;
    assign axi_arready = ar_take_reg;
    assign axi_rvalid  = rvalid_reg;
    assign axi_rresp   = rresp_reg;
    assign axi_rdata   = rdata_reg;
    assign irq         = irq_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_tick;
        ins_tick;
    endsequence

    sequence s_quiet3;
        !ins_tick [*3];
    endsequence

    property p_ins_tick;
        @(posedge clk) disable iff (!rst_b) s_tick |=> s_quiet3 ##1 ins_tick;
    endproperty
    a_ins_tick: assert property (p_ins_tick) else $error("instruction tick not every fourth cycle"); // R1

    property p_count_step;
        @(posedge clk) disable iff (!rst_b)
            (pre_pulse && !wr_count && count_reg != period_reg) |=> count_reg == $past(count_reg) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not advance"); // R3

    property p_wrap;
        @(posedge clk) disable iff (!rst_b) match |=> (count_reg == `TMR_COUNT_RST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap on match"); // R4

    property p_flag_set;
        @(posedge clk) disable iff (!rst_b) post_pulse |=> flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("postscaled event did not set flag"); // R5

    property p_reset_values;
        @(posedge clk) !rst_b |=> (count_reg == `TMR_COUNT_RST && period_reg == `TMR_PERIOD_RST);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("wrong reset values"); // R7

    property p_stopped;
        @(posedge clk) disable iff (!rst_b)
            (!run && !wr_count) |-> (!match && !post_pulse) ##1 count_reg == $past(count_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped timer moved"); // R8

    property p_control_keeps_count;
        @(posedge clk) disable iff (!rst_b) (wr_control && !pre_pulse) |=> $stable(count_reg);
    endproperty
    a_control_keeps_count: assert property (p_control_keeps_count) else $error("control write changed count"); // R10

    property p_flag_sticky;
        @(posedge clk) disable iff (!rst_b)
            (flag_reg && !(wr_clear && axi_wdata[`TMR_IRQ_BIT])) |=> flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // R11

    property p_flag_no_enable;
        @(posedge clk) disable iff (!rst_b) (post_pulse && !enable_reg) |=> flag_reg && !irq_reg;
    endproperty
    a_flag_no_enable: assert property (p_flag_no_enable) else $error("flag gated by enable"); // R12

    property p_scaler_gate;
        @(posedge clk) disable iff (!rst_b) !run |-> !pre_pulse;
    endproperty
    a_scaler_gate: assert property (p_scaler_gate) else $error("prescaler ran while off"); // R13

endmodule : period_match_timer8

// File: tb/period_match_timer8_tb_top.sv
// self-checking register-level testbench for the period match timer
`timescale 1ns/1ps
`include "period_timer_defines.svh"

module period_match_timer8_tb_top;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        clk;                 // 50 ns bus and timer clock
    logic        rst_b;               // synchronous reset, active low
    logic [4:0]  axi_awaddr;
    logic        axi_awvalid;
    logic        axi_awready;
    logic [31:0] axi_wdata;
    logic [3:0]  axi_wstrb;
    logic        axi_wvalid;
    logic        axi_wready;
    logic [1:0]  axi_bresp;
    logic        axi_bvalid;
    logic        axi_bready;
    logic [4:0]  axi_araddr;
    logic        axi_arvalid;
    logic        axi_arready;
    logic [31:0] axi_rdata;
    logic [1:0]  axi_rresp;
    logic        axi_rvalid;
    logic        axi_rready;
    logic        irq;                 // level interrupt under test
    int          num_errors = 0;      // mismatches seen
    int          samples_checked = 0; // comparisons made
    int          cyc = 0;             // cycle stamp for interval timing
    int          t1;                  // first interrupt rise
    int          t2;                  // second interrupt rise
    logic [1:0]  pre_codes [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [3:0]  post_codes [5] = '{4'hF, 4'h1, 4'h2, 4'h0, 4'h1};
    int          pre_divs [5] = '{1, 4, 16, 16, 1};

    period_match_timer8 period_match_timer8_i (.clk(clk), .rst_b(rst_b), .axi_awaddr(axi_awaddr),
        .axi_awvalid(axi_awvalid), .axi_awready(axi_awready), .axi_wdata(axi_wdata), .axi_wstrb(axi_wstrb),
        .axi_wvalid(axi_wvalid), .axi_wready(axi_wready), .axi_bresp(axi_bresp), .axi_bvalid(axi_bvalid),
        .axi_bready(axi_bready), .axi_araddr(axi_araddr), .axi_arvalid(axi_arvalid), .axi_arready(axi_arready),
        .axi_rdata(axi_rdata), .axi_rresp(axi_rresp), .axi_rvalid(axi_rvalid), .axi_rready(axi_rready),
        .irq(irq));

    // ----------------------------------------------------------------
    // clock and cycle stamp
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    // ----------------------------------------------------------------
    // verdict, comparison and bus tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // address and data offered together, each released when taken; bready held until bvalid
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        int   n;
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open = 1'b1;
        axi_awaddr <= a;
        axi_wdata <= d;
        axi_awvalid <= 1'b1;
        axi_wvalid <= 1'b1;
        axi_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (!aw_open && !w_open && axi_bvalid === 1'b1)
                break;
            if (aw_open && axi_awready === 1'b1)
            begin
                aw_open = 1'b0;
                axi_awvalid <= 1'b0;
            end
            if (w_open && axi_wready === 1'b1)
            begin
                w_open = 1'b0;
                axi_wvalid <= 1'b0;
            end
        end
        axi_bready <= 1'b0;
        if (n == 50)
        begin
            num_errors++;
            conclude();
        end
        chk("bresp", {30'h0, axi_bresp}, {30'h0, exp_resp});
    endtask : wr

    // read one word and compare data and response
    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        int n;
        axi_araddr <= a;
        axi_arvalid <= 1'b1;
        axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (axi_arready === 1'b1)
                axi_arvalid <= 1'b0;
            if (axi_rvalid === 1'b1)
                break;
        end
        axi_rready <= 1'b0;
        if (n == 50)
        begin
            num_errors++;
            conclude();
        end
        chk("rdata", axi_rdata, exp);
        chk("rresp", {30'h0, axi_rresp}, {30'h0, exp_resp});
    endtask : rd

    // stamp the next low-to-high change of the interrupt line
    task automatic irq_rise(output int t);
        int   n;
        logic low_seen;
        low_seen = 1'b0;
        for (n = 0; n < 4000; n++)
        begin
            @(posedge clk);
            if (low_seen && irq === 1'b1)
                break;
            if (irq === 1'b0)
                low_seen = 1'b1;
        end
        t = cyc;
        if (n == 4000)
        begin
            num_errors++;
            conclude();
        end
    endtask : irq_rise

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        {axi_awaddr, axi_awvalid, axi_wdata, axi_wstrb, axi_wvalid, axi_bready} = '0;
        {axi_araddr, axi_arvalid, axi_rready} = '0;
        axi_wstrb = 4'hF;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // reset values and register map
        rd(`TMR_OFS_COUNT, 32'h00, 2'h0);
        rd(`TMR_OFS_PERIOD, 32'hFF, 2'h0);
        rd(`TMR_OFS_CONTROL, 32'h00, 2'h0);
        rd(`TMR_OFS_FLAGS, 32'h00, 2'h0);
        rd(`TMR_OFS_ENABLES, 32'h00, 2'h0);
        rd(5'h18, 32'h00, period_timer_pkg::RESP_SLVERR);
        wr(5'h1C, 32'h55, period_timer_pkg::RESP_SLVERR);
        // a stopped timer holds its count; a control write keeps it
        wr(`TMR_OFS_COUNT, 32'h5A, 2'h0);
        wr(`TMR_OFS_CONTROL, 32'h7B, 2'h0);
        repeat (80) @(posedge clk);
        rd(`TMR_OFS_COUNT, 32'h5A, 2'h0);
        rd(`TMR_OFS_CONTROL, 32'h7B, 2'h0);
        rd(`TMR_OFS_FLAGS, 32'h00, 2'h0);
        // flag sets with its enable low, and the line stays quiet
        wr(`TMR_OFS_PERIOD, 32'h00, 2'h0);
        wr(`TMR_OFS_COUNT, 32'h00, 2'h0);
        wr(`TMR_OFS_CONTROL, 32'h04, 2'h0);
        repeat (20) @(posedge clk);
        rd(`TMR_OFS_FLAGS, 32'h02, 2'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rd(`TMR_OFS_CLEAR, 32'h00, 2'h0);
        // interval between interrupts for each prescale code and several postscales
        wr(`TMR_OFS_PERIOD, 32'h05, 2'h0);
        wr(`TMR_OFS_ENABLES, 32'h02, 2'h0);
        for (int k = 0; k < 5; k++)
        begin
            wr(`TMR_OFS_CONTROL, {25'h0, post_codes[k], 1'b1, pre_codes[k]}, 2'h0);
            wr(`TMR_OFS_CLEAR, 32'h02, 2'h0);
            irq_rise(t1);
            rd(`TMR_OFS_FLAGS, 32'h02, 2'h0);
            wr(`TMR_OFS_CLEAR, 32'h02, 2'h0);
            irq_rise(t2);
            chk("interval", 32'(t2 - t1), 32'(6 * pre_divs[k] * (int'(post_codes[k]) + 1) * 4));
        end
        // stop and confirm the count no longer moves
        wr(`TMR_OFS_CONTROL, 32'h00, 2'h0);
        wr(`TMR_OFS_COUNT, 32'h03, 2'h0);
        repeat (40) @(posedge clk);
        rd(`TMR_OFS_COUNT, 32'h03, 2'h0);
        conclude();
    end

endmodule : period_match_timer8_tb_top
